/* File: rtl/maf_defs.svh */
// Purpose: offsets, field positions and reset values of the address filter
// Assumes: 12-bit byte address on the register bus
// Notes: definitions only
`ifndef MAF_DEFS_SVH
`define MAF_DEFS_SVH
`define MAF_OFF_CTRL 12'h100
`define MAF_OFF_ADRH 12'h104
`define MAF_OFF_ADRL 12'h108
`define MAF_OFF_HSHH 12'h10C
`define MAF_OFF_HSHL 12'h110
`define MAF_OFF_STAT 12'h120
`define MAF_BIT_RXG 2
`define MAF_BIT_TXG 3
`define MAF_BIT_ALLG 19
`define MAF_BIT_PROT 31
`define MAF_RST_ADRH 16'hFFFF
`define MAF_RST_ADRL 32'hFFFF_FFFF
`define MAF_RST_HASH 32'h0000_0000
`define MAF_CRC_POLY 32'h04C1_1DB7
`define MAF_CRC_INIT 32'hFFFF_FFFF
`define MAF_HDR_LAST 3'h5
`endif

/* File: rtl/maf_pkg.sv */
// Purpose: types shared by the address filter and its bench
// Assumes: nothing
// Notes: receive states gray coded along hdr-flush-pass
package maf_pkg;
    typedef enum logic [1:0] {
        MAF_HDR   = 2'h0,
        MAF_FLUSH = 2'h1,
        MAF_PASS  = 2'h3,
        MAF_DROP  = 2'h2
    } maf_state_e;
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } maf_byte_s;
    typedef struct packed {
        logic prot;
        logic allg;
        logic txg;
        logic rxg;
    } maf_ctrl_s;
endpackage

/* File: rtl/maf_filter.sv */
// Purpose: station address, group hash filter and tx/rx gating of a MAC
// Assumes: one clock, byte streams with a last flag, APB register access
// Notes: filter holds the six destination bytes, then forwards or drops
//
// Contract
// RQ1 - transmit gate set sends frames to the cable; clear sends none (a frame started before the gate clears is still sent whole)
// RQ2 - receive gate set accepts frames from the phy; clear accepts none
// RQ3 - station address high holds bits 47:32, read/write, resets to ones
// RQ4 - station address low holds bits 31:0, read/write, resets to ones
// RQ5 - first octet in low bits 7:0, sixth octet in high bits 15:8
// RQ6 - protected reset keeps both station address registers
// RQ7 - hash index msb picks upper or lower word, five bits pick the bit
// RQ8 - group frame accepted when its hash bit is one, else rejected
// RQ9 - accept all group frames overrides the hash table
// RQ10 - upper hash word read/write, resets to zero
// RQ11 - lower hash word read/write, resets to zero
// RQ12 - hash index comes from crc-32 over the six destination octets
// RQ13 - reserved bits read zero and ignore writes

`include "maf_defs.svh"

module maf_fifo #(
    parameter int W  = 9,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    input  wire logic          i_clock,
    input  wire logic          i_resetn,
    input  wire logic          i_valid,
    input  wire logic [W-1:0]  i_data,
    output logic               o_ready,
    output logic               o_valid,
    output logic [W-1:0]       o_data,
    input  wire logic          i_ready,
    output logic [AW:0]        o_count
);
    // depth must be a power of two: pointers wrap by overflow
    logic [W-1:0] mem_q [0:D-1];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;
    logic         push;
    logic         pop;

    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_count = wp_q - rp_q;
    assign o_ready = o_count != D[AW:0];
    assign o_valid = o_count != '0;
    assign o_data  = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule // maf_fifo

module maf_filter #(
    parameter int DEPTH = 16
) (
    input  wire logic             i_clock,
    input  wire logic             i_resetn,
    input  wire logic             i_soft_reset,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [11:0]      i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic [31:0]           o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    input  wire logic             i_phy_rx_valid,
    input  wire maf_pkg::maf_byte_s i_phy_rx_byte,
    output logic                  o_phy_rx_ready,
    output logic                  o_rx_valid,
    output maf_pkg::maf_byte_s    o_rx_byte,
    input  wire logic             i_rx_ready,
    input  wire logic             i_tx_valid,
    input  wire maf_pkg::maf_byte_s i_tx_byte,
    output logic                  o_tx_ready,
    output logic                  o_phy_tx_valid,
    output maf_pkg::maf_byte_s    o_phy_tx_byte,
    input  wire logic             i_phy_tx_ready
);
    localparam int CW = $clog2(DEPTH) + 1;

    maf_pkg::maf_ctrl_s  ctrl_q;
    maf_pkg::maf_state_e state_q;
    maf_pkg::maf_byte_s  fin_byte;
    maf_pkg::maf_byte_s  tx_q;
    logic [15:0]         addr_hi_q;
    logic [31:0]         addr_lo_q;
    logic [31:0]         hash_hi_q;
    logic [31:0]         hash_lo_q;
    logic [31:0]         rd_val;
    logic                hit;
    logic                setup;
    logic                wr;
    logic [7:0]          hdr_q [0:5];
    logic [2:0]          cnt_q;
    logic [31:0]         crc_q;
    logic [31:0]         crc_nxt;
    logic                hdr_last_q;
    logic [7:0]          acc_cnt_q;
    logic [7:0]          rej_cnt_q;
    logic [47:0]         dest;
    logic                mcast;
    logic [5:0]          hidx;
    logic                hbit;
    logic                accept;
    logic                rx_take;
    logic                decide;
    logic                fin_valid;
    logic                fin_ready;
    logic [CW-1:0]       fifo_cnt;
    logic                tx_vq;
    logic                tx_busy_q;
    logic                tx_take;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 8; k++) begin
            r = (r[31] ^ b[k]) ? ({r[30:0], 1'b0} ^ `MAF_CRC_POLY) : {r[30:0], 1'b0};
        end
        return r;
    endfunction

    // register bus: read data caught in setup, zero wait access
    assign setup     = i_psel && !i_penable;
    assign wr        = i_psel && i_penable && i_pwrite && hit;
    assign o_pready  = 1'b1;

    always_comb begin
        rd_val = '0;
        hit    = 1'b1;
        case (i_paddr)
            `MAF_OFF_CTRL: begin
                rd_val[`MAF_BIT_PROT] = ctrl_q.prot;
                rd_val[`MAF_BIT_ALLG] = ctrl_q.allg;
                rd_val[`MAF_BIT_TXG]  = ctrl_q.txg;
                rd_val[`MAF_BIT_RXG]  = ctrl_q.rxg;
            end
            `MAF_OFF_ADRH: rd_val = {16'h0000, addr_hi_q}; // [RQ13]
            `MAF_OFF_ADRL: rd_val = addr_lo_q;
            `MAF_OFF_HSHH: rd_val = hash_hi_q;
            `MAF_OFF_HSHL: rd_val = hash_lo_q;
            `MAF_OFF_STAT: rd_val = {rej_cnt_q, acc_cnt_q, 8'h00, 1'b0, state_q, 5'(fifo_cnt)};
            default:       hit    = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata  <= rd_val;
            o_pslverr <= !hit;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_q <= '0;
        end else if (i_soft_reset) begin
            ctrl_q <= '0;
        end else if (wr && i_paddr == `MAF_OFF_CTRL) begin
            ctrl_q.prot <= i_pwdata[`MAF_BIT_PROT];
            ctrl_q.allg <= i_pwdata[`MAF_BIT_ALLG];
            ctrl_q.txg  <= i_pwdata[`MAF_BIT_TXG];
            ctrl_q.rxg  <= i_pwdata[`MAF_BIT_RXG];
        end
    end

    // soft reset spares the station address while protection is set
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            addr_hi_q <= `MAF_RST_ADRH; // [RQ3]
            addr_lo_q <= `MAF_RST_ADRL; // [RQ4]
        end else if (i_soft_reset) begin
            if (!ctrl_q.prot) begin // [RQ6]
                addr_hi_q <= `MAF_RST_ADRH;
                addr_lo_q <= `MAF_RST_ADRL;
            end
        end else if (wr && i_paddr == `MAF_OFF_ADRH) begin
            addr_hi_q <= i_pwdata[15:0]; // [RQ3] [RQ13]
        end else if (wr && i_paddr == `MAF_OFF_ADRL) begin
            addr_lo_q <= i_pwdata; // [RQ4]
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            hash_hi_q <= `MAF_RST_HASH; // [RQ10]
            hash_lo_q <= `MAF_RST_HASH; // [RQ11]
        end else if (i_soft_reset) begin
            hash_hi_q <= `MAF_RST_HASH;
            hash_lo_q <= `MAF_RST_HASH;
        end else if (wr && i_paddr == `MAF_OFF_HSHH) begin
            hash_hi_q <= i_pwdata; // [RQ10]
        end else if (wr && i_paddr == `MAF_OFF_HSHL) begin
            hash_lo_q <= i_pwdata; // [RQ11]
        end
    end

    // receive filter
    assign rx_take = i_phy_rx_valid && o_phy_rx_ready;
    assign decide  = state_q == maf_pkg::MAF_HDR && rx_take && cnt_q == `MAF_HDR_LAST;
    assign crc_nxt = crc_byte((cnt_q == 3'h0) ? `MAF_CRC_INIT : crc_q, i_phy_rx_byte.data); // [RQ12]
    assign dest    = {i_phy_rx_byte.data, hdr_q[4], hdr_q[3], hdr_q[2], hdr_q[1], hdr_q[0]}; // [RQ5]
    assign mcast   = hdr_q[0][0];
    assign hidx    = crc_nxt[31:26]; // [RQ12]
    assign hbit    = hidx[5] ? hash_hi_q[hidx[4:0]] : hash_lo_q[hidx[4:0]]; // [RQ7]
    // broadcast is a group address too and goes through the hash
    assign accept  = ctrl_q.rxg && (mcast ? (ctrl_q.allg || hbit) // [RQ2] [RQ8] [RQ9]
                                          : dest == {addr_hi_q, addr_lo_q}); // [RQ5]

    always_comb begin
        case (state_q)
            maf_pkg::MAF_FLUSH: o_phy_rx_ready = 1'b0;
            maf_pkg::MAF_PASS:  o_phy_rx_ready = fin_ready;
            default:            o_phy_rx_ready = 1'b1;
        endcase
    end

    assign fin_valid = state_q == maf_pkg::MAF_FLUSH || (state_q == maf_pkg::MAF_PASS && i_phy_rx_valid);
    assign fin_byte  = (state_q == maf_pkg::MAF_FLUSH)
                     ? {hdr_last_q && cnt_q == `MAF_HDR_LAST, hdr_q[cnt_q]} : i_phy_rx_byte;

    always_ff @(posedge i_clock) begin
        if (state_q == maf_pkg::MAF_HDR && rx_take) begin
            hdr_q[cnt_q] <= i_phy_rx_byte.data;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q    <= maf_pkg::MAF_HDR;
            cnt_q      <= '0;
            crc_q      <= `MAF_CRC_INIT;
            hdr_last_q <= 1'b0;
        end else if (i_soft_reset) begin
            state_q <= maf_pkg::MAF_HDR;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                maf_pkg::MAF_HDR: begin
                    if (rx_take) begin
                        crc_q <= crc_nxt;
                        if (decide) begin
                            cnt_q      <= '0;
                            hdr_last_q <= i_phy_rx_byte.last;
                            if (accept) begin
                                state_q <= maf_pkg::MAF_FLUSH;
                            end else if (!i_phy_rx_byte.last) begin
                                state_q <= maf_pkg::MAF_DROP;
                            end
                        end else if (i_phy_rx_byte.last) begin
                            cnt_q <= '0; // runt frame discarded
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                maf_pkg::MAF_FLUSH: begin
                    if (fin_ready) begin
                        if (cnt_q == `MAF_HDR_LAST) begin
                            cnt_q   <= '0;
                            state_q <= hdr_last_q ? maf_pkg::MAF_HDR : maf_pkg::MAF_PASS;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                maf_pkg::MAF_PASS, maf_pkg::MAF_DROP: begin
                    if (rx_take && i_phy_rx_byte.last) begin
                        state_q <= maf_pkg::MAF_HDR;
                    end
                end
                default: state_q <= maf_pkg::MAF_HDR;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_cnt_q <= '0;
            rej_cnt_q <= '0;
        end else if (decide && accept) begin
            acc_cnt_q <= acc_cnt_q + 8'h01;
        end else if (state_q == maf_pkg::MAF_HDR && rx_take && i_phy_rx_byte.last) begin
            rej_cnt_q <= rej_cnt_q + 8'h01;
        end
    end

    maf_fifo #(
        .W (9),
        .D (DEPTH)
    ) u_fifo (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_valid  (fin_valid),
        .i_data   (fin_byte),
        .o_ready  (fin_ready),
        .o_valid  (o_rx_valid),
        .o_data   (o_rx_byte),
        .i_ready  (i_rx_ready),
        .o_count  (fifo_cnt)
    );

    // transmit: gate checked at frame start so no frame is cut short
    assign o_tx_ready     = (tx_busy_q || ctrl_q.txg) && (!tx_vq || i_phy_tx_ready); // [RQ1]
    assign tx_take        = i_tx_valid && o_tx_ready;
    assign o_phy_tx_valid = tx_vq;
    assign o_phy_tx_byte  = tx_q;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_vq     <= 1'b0;
            tx_q      <= '0;
            tx_busy_q <= 1'b0;
        end else if (tx_take) begin
            tx_vq     <= 1'b1;
            tx_q      <= i_tx_byte;
            tx_busy_q <= !i_tx_byte.last;
        end else if (i_phy_tx_ready) begin
            tx_vq <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    sequence apb_setup_s(logic [11:0] a);
        i_psel && !i_penable && i_paddr == a;
    endsequence
    sequence apb_access_s;
        i_psel && i_penable;
    endsequence

    tx_gate_hold_a: assert property (!ctrl_q.txg && !tx_busy_q |-> !o_tx_ready) // [RQ1]
        else $error("frame started with transmit gate clear");
    rx_gate_drop_a: assert property (decide && !ctrl_q.rxg |=> state_q != maf_pkg::MAF_FLUSH) // [RQ2]
        else $error("frame forwarded with receive gate clear");
    adrh_read_a: assert property (apb_setup_s(`MAF_OFF_ADRH) ##1 apb_access_s |->
        o_prdata == {16'h0000, $past(addr_hi_q)}) // [RQ13]
        else $error("address high read wrong");
    addr_default_a: assert property (i_soft_reset && !ctrl_q.prot |=>
        addr_lo_q == `MAF_RST_ADRL && addr_hi_q == `MAF_RST_ADRH) // [RQ4]
        else $error("station address not restored");
    addr_protect_a: assert property (i_soft_reset && ctrl_q.prot |=>
        $stable(addr_lo_q) && $stable(addr_hi_q)) // [RQ6]
        else $error("protected station address lost");
    uni_match_a: assert property (decide && !mcast && ctrl_q.rxg && dest == {addr_hi_q, addr_lo_q}
        |=> state_q == maf_pkg::MAF_FLUSH ##1 state_q == maf_pkg::MAF_FLUSH or !fin_ready) // [RQ5]
        else $error("matching unicast frame not forwarded");
    hash_zero_a: assert property (decide && mcast && ctrl_q.rxg && !ctrl_q.allg && hidx == 6'h00
        |=> state_q == (hash_lo_q[0] ? maf_pkg::MAF_FLUSH : $past(i_phy_rx_byte.last)
        ? maf_pkg::MAF_HDR : maf_pkg::MAF_DROP)) // [RQ7]
        else $error("index zero did not use lower bit zero");
    hash_reject_a: assert property (decide && mcast && !ctrl_q.allg && !hbit |=>
        state_q != maf_pkg::MAF_FLUSH) // [RQ8]
        else $error("group frame with clear hash bit accepted");
    all_group_a: assert property (decide && mcast && ctrl_q.allg && ctrl_q.rxg |=>
        state_q == maf_pkg::MAF_FLUSH) // [RQ9]
        else $error("group frame rejected with accept all set");
    hash_write_a: assert property (wr && i_paddr == `MAF_OFF_HSHH && !i_soft_reset |=>
        hash_hi_q == $past(i_pwdata)) // [RQ10]
        else $error("upper hash write lost");
endmodule // maf_filter

/* File: verification/maf_phy_model.sv */
// Purpose: phy side partner of the address filter
// Assumes: frames handed in by task, one byte a beat
// Notes: a released data line shows the inverse of its last byte
module maf_phy_model (
    input  wire logic          i_clock,
    input  wire logic          i_slow,
    output maf_pkg::maf_byte_s o_rx_byte,
    output logic               o_rx_valid,
    input  wire logic          i_rx_ready,
    output logic               o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_byte  = '0;
        o_tx_ready = 1'b1;
    end
    // slow mode stalls every other beat so the output stage must hold
    always @(posedge i_clock) o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
    task automatic send_frame(input maf_pkg::maf_byte_s f[$]);
        @(posedge i_clock);
        foreach (f[i]) begin
            o_rx_valid <= 1'b1;
            o_rx_byte  <= f[i];
            do @(posedge i_clock); while (i_rx_ready !== 1'b1);
            if (i_slow || i == f.size() - 1) begin
                o_rx_valid <= 1'b0;
                o_rx_byte  <= ~f[i];
                if (i_slow) @(posedge i_clock);
            end
        end
    endtask
endmodule // maf_phy_model

/* File: verification/maf_filter_test.sv */
// Purpose: self-checking bench of the address filter
// Assumes: apb master, phy model, queued expectations
// Notes: expected data come from the bench's own crc and address model
`include "maf_defs.svh"
module maf_filter_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed { logic [31:0] data; logic err; } maf_exp_s;
    logic               clock = 1'b0, resetn = 1'b0, soft_reset = 1'b0, slow = 1'b0, hold_rx = 1'b0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0000_0000, prdata, seed = 32'h835e_9b95;
    logic               phy_rx_valid, phy_rx_ready, rx_valid, rx_ready = 1'b0, tx_valid = 1'b0, tx_ready;
    logic               phy_tx_valid, phy_tx_ready;
    maf_pkg::maf_byte_s phy_rx_byte, rx_byte, phy_tx_byte, tx_byte = '0;
    maf_pkg::maf_byte_s rx_q[$], tx_q[$];
    maf_exp_s           rd_q[$], e;
    logic [47:0]        dst;
    logic [63:0]        h;
    int                 fails = 0, compares = 0;
    localparam logic [47:0] STN = 48'hBC9A_7856_3412;
    always #50 clock = ~clock;
    maf_filter maf_filter_inst (.i_clock(clock), .i_resetn(resetn), .i_soft_reset(soft_reset),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_phy_rx_valid(phy_rx_valid),
        .i_phy_rx_byte(phy_rx_byte), .o_phy_rx_ready(phy_rx_ready), .o_rx_valid(rx_valid),
        .o_rx_byte(rx_byte), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
        .o_tx_ready(tx_ready), .o_phy_tx_valid(phy_tx_valid), .o_phy_tx_byte(phy_tx_byte),
        .i_phy_tx_ready(phy_tx_ready));
    maf_phy_model maf_phy_model_inst (.i_clock(clock), .i_slow(slow), .o_rx_byte(phy_rx_byte),
        .o_rx_valid(phy_rx_valid), .i_rx_ready(phy_rx_ready), .o_tx_ready(phy_tx_ready));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // octet one first, each octet lsb first, no final inversion
    function automatic logic [5:0] hash_idx(input logic [47:0] d);
        logic [31:0] c;
        c = 32'hFFFF_FFFF;
        for (int i = 0; i < 48; i++) c = (c << 1) ^ ((c[31] ^ d[i]) ? 32'h04C1_1DB7 : 32'h0000_0000);
        return c[31:26];
    endfunction
    task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
        rd_q.push_back('{d, err});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic pulse_soft();
        @(posedge clock);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
    endtask
    task automatic drain();
        for (int k = 0; k < 600 && rx_q.size() + tx_q.size() != 0; k++) @(posedge clock);
        repeat (20) @(posedge clock);
        cmp_word("pending bytes", 32'h0000_0000, 32'(rx_q.size() + tx_q.size()));
    endtask
    task automatic rx_frame(input logic [47:0] d, input int n, input logic acc);
        maf_pkg::maf_byte_s f[$];
        for (int i = 0; i < 6 + n; i++) begin
            f.push_back(maf_pkg::maf_byte_s'({i == 5 + n, i < 6 ? d[8*i +: 8] : 8'(xs())}));
            if (acc) rx_q.push_back(f[i]);
        end
        maf_phy_model_inst.send_frame(f);
        drain();
    endtask
    task automatic tx_frame(input int n);
        maf_pkg::maf_byte_s b;
        @(posedge clock);
        for (int i = 0; i < n; i++) begin
            b = maf_pkg::maf_byte_s'({i == n - 1, 8'(xs())});
            tx_valid <= 1'b1;
            tx_byte  <= b;
            tx_q.push_back(b);
            do @(posedge clock); while (tx_ready !== 1'b1);
        end
        tx_valid <= 1'b0;
    endtask
    always @(posedge clock) rx_ready <= !hold_rx && (xs() % 4 != 0);
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite) begin
            e = rd_q.pop_front();
            cmp_word("read data", e.data, prdata);
            cmp_word("slave error", 32'(e.err), 32'(pslverr));
        end
        if (rx_valid && rx_ready)
            cmp_word("rx byte", rx_q.size() ? 32'(rx_q.pop_front()) : 32'hFFFF_FFFF, 32'(rx_byte));
        if (phy_tx_valid && phy_tx_ready)
            cmp_word("tx byte", tx_q.size() ? 32'(tx_q.pop_front()) : 32'hFFFF_FFFF, 32'(phy_tx_byte));
    end
    initial begin
        #2_000_000;
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rd(`MAF_OFF_ADRH, 32'h0000_FFFF, 1'b0);
        rd(`MAF_OFF_ADRL, 32'hFFFF_FFFF, 1'b0);
        rd(`MAF_OFF_HSHH, 32'h0000_0000, 1'b0);
        rd(`MAF_OFF_HSHL, 32'h0000_0000, 1'b0);
        rd(12'h114, 32'h0000_0000, 1'b1);
        apb(1'b1, `MAF_OFF_ADRH, 32'hFFFF_BC9A);
        apb(1'b1, `MAF_OFF_ADRL, 32'h7856_3412);
        apb(1'b1, `MAF_OFF_HSHH, 32'hA5A5_5A5A);
        apb(1'b1, `MAF_OFF_HSHL, 32'h5A5A_A5A5);
        apb(1'b1, `MAF_OFF_CTRL, 32'hFFFF_FFFF);
        rd(`MAF_OFF_ADRH, 32'h0000_BC9A, 1'b0);
        rd(`MAF_OFF_ADRL, 32'h7856_3412, 1'b0);
        rd(`MAF_OFF_HSHH, 32'hA5A5_5A5A, 1'b0);
        rd(`MAF_OFF_HSHL, 32'h5A5A_A5A5, 1'b0);
        rd(`MAF_OFF_CTRL, 32'h8008_000C, 1'b0);
        $display("test registers done");
        pulse_soft();
        rd(`MAF_OFF_ADRL, 32'h7856_3412, 1'b0);
        rd(`MAF_OFF_ADRH, 32'h0000_BC9A, 1'b0);
        rd(`MAF_OFF_CTRL, 32'h0000_0000, 1'b0);
        pulse_soft();
        rd(`MAF_OFF_ADRL, 32'hFFFF_FFFF, 1'b0);
        rd(`MAF_OFF_ADRH, 32'h0000_FFFF, 1'b0);
        apb(1'b1, `MAF_OFF_ADRH, 32'h0000_BC9A);
        apb(1'b1, `MAF_OFF_ADRL, 32'h7856_3412);
        $display("test protected reset done");
        rx_frame(STN, 4, 1'b0);
        apb(1'b1, `MAF_OFF_CTRL, 32'h0000_0004);
        rx_frame(STN, 8, 1'b1);
        rx_frame(STN ^ 48'h0100_0000_0000, 5, 1'b0);
        rx_frame(STN ^ 48'h0000_0000_0006, 5, 1'b0);
        hold_rx <= 1'b1;
        fork
            rx_frame(STN, 24, 1'b1);
            begin
                repeat (60) @(posedge clock);
                cmp_word("phy rx ready", 32'h0000_0000, 32'(phy_rx_ready));
                hold_rx <= 1'b0;
            end
        join
        $display("test station filter done");
        for (int k = 0; k < 8; k++) begin
            dst = {16'(xs()), xs()} | 48'h0000_0000_0001;
            h   = {xs(), xs()};
            apb(1'b1, `MAF_OFF_HSHH, h[63:32]);
            apb(1'b1, `MAF_OFF_HSHL, h[31:0]);
            rx_frame(dst, 3, h[hash_idx(dst)]);
        end
        // index zero must land on lower word bit zero
        do dst = {16'(xs()), xs()} | 48'h0000_0000_0001; while (hash_idx(dst) != 6'h00);
        apb(1'b1, `MAF_OFF_HSHL, 32'h0000_0001);
        rx_frame(dst, 3, 1'b1);
        apb(1'b1, `MAF_OFF_HSHH, 32'h0000_0000);
        apb(1'b1, `MAF_OFF_HSHL, 32'h0000_0000);
        rx_frame(dst, 3, 1'b0);
        apb(1'b1, `MAF_OFF_CTRL, 32'h0008_0004);
        rx_frame(dst, 3, 1'b1);
        $display("test group hash done");
        @(posedge clock);
        tx_valid <= 1'b1;
        repeat (10) begin
            @(posedge clock);
            cmp_word("tx ready", 32'h0000_0000, 32'(tx_ready));
        end
        tx_valid <= 1'b0;
        slow     <= 1'b1;
        apb(1'b1, `MAF_OFF_CTRL, 32'h0000_0008);
        tx_frame(7);
        drain();
        $display("test transmit done");
        tally_and_finish();
    end
endmodule // maf_filter_test
